// ### src/pom_pkg.sv
package pom_pkg;

   // ***************************************************
   // Array geometry
   // ***************************************************
   localparam int NUM_IN = 12;
   localparam int NUM_MC = 10;
   localparam int NUM_SIG = NUM_IN + NUM_MC;
   localparam int NUM_COL = 2 * NUM_SIG;
   localparam int MAX_PT = 16;
   localparam int NUM_TERMS = 132;
   localparam int PAD_TERMS = NUM_TERMS + MAX_PT;
   localparam int AR_TERM = 0;
   localparam int SP_TERM = 1;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] CFG_ADDR = 12'h004;
   localparam logic [11:0] STATUS_ADDR = 12'h008;
   localparam logic [11:0] ARRAY_BASE = 12'h400;
   localparam int PRELOAD_BIT = 0;
   localparam int CFG_POL_LSB = 0;
   localparam int CFG_PATH_LSB = 16;
   localparam int STATUS_PIN_LSB = 16;
   localparam logic [9:0] CFG_ERASED = 10'h3FF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sum terms per macrocell, narrow at the ends and wide in the middle
   function automatic int ptCount(input int m);
      case (m)
         0, 9: return 8;
         1, 8: return 10;
         2, 7: return 12;
         3, 6: return 14;
         default: return 16;
      endcase
   endfunction

   // Row of a macrocell's enable term; its sum terms follow it
   function automatic int ptBase(input int m);
      int b;
      b = 2;
      for (int j = 0; j < m; j++) begin
         b = b + ptCount(j) + 1;
      end
      return b;
   endfunction

endpackage

// ### src/pom_top.sv
`timescale 1ns/10ps

// Notes on behaviour
// [R1] Twelve inputs, ten macrocells, each pin bidirectional
// [R2] Eight to sixteen sum terms per macrocell
// [R3] Term with no connections evaluates high
// [R4] Term with true and complement is low
// [R5] Every input offers true and complement forms
// [R6] Registered or combinatorial, either polarity, two bits
// [R7] Programmed bit selects 0, erased selects 1
// [R8] Flip-flop captures sum on rising clock
// [R9] Path 0: registered, feedback from inverted flop
// [R10] Path 1: bypass flop, feedback from pin
// [R11] Dedicated product term enables each output buffer
// [R12] Disabled combinatorial macrocell works as input
// [R13] Polarity bit 1 gives active high output
// [R14] Preset term loads flops high next edge
// [R15] Reset term clears flops immediately, no clock
// [R16] Preset and reset act before polarity
// [R17] Flops start low after power-up reset
// [R18] Test preload loads flops from pins
// [R19] Reset term wins over preset term
module pom_top (
   input wire logic clock,
   input wire logic reset,
   input wire logic [pom_pkg::NUM_IN-1:0] inPin,
   input wire logic [pom_pkg::NUM_MC-1:0] ioIn,
   output logic [pom_pkg::NUM_MC-1:0] ioOut,
   output logic [pom_pkg::NUM_MC-1:0] ioOe,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pom_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [pom_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);

   // ***************************************************
   // Configuration state
   // ***************************************************
   logic [pom_pkg::NUM_COL-1:0] termConn [pom_pkg::NUM_TERMS];
   logic [pom_pkg::NUM_MC-1:0] polaritySelectBit;
   logic [pom_pkg::NUM_MC-1:0] outputPathSelectBit;
   logic preloadMode;

   // ***************************************************
   // Array signals
   // ***************************************************
   logic [pom_pkg::NUM_MC-1:0] flop;
   logic [pom_pkg::NUM_MC-1:0] feedback;
   logic [pom_pkg::NUM_SIG-1:0] arraySig;
   logic [pom_pkg::NUM_COL-1:0] literal;
   logic [pom_pkg::PAD_TERMS-1:0] termVal;
   logic [pom_pkg::NUM_MC-1:0] orSum;
   logic [pom_pkg::NUM_MC-1:0] enableTerm;
   logic [pom_pkg::NUM_MC-1:0] cellData;
   logic asyncResetTerm;
   logic syncPresetTerm;

   // ***************************************************
   // Bus signals
   // ***************************************************
   logic awHeld;
   logic wHeld;
   logic [pom_pkg::ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;
   logic [pom_pkg::ADDR_W-1:0] wrOffset;
   logic [pom_pkg::ADDR_W-1:0] rdOffset;
   logic [7:0] wrIdx;
   logic [7:0] rdIdx;
   logic wrIsTerm;
   logic rdIsTerm;
   logic wrMapped;
   logic rdMapped;
   logic [31:0] rdWord;

   // ***************************************************
   // AND array
   // ***************************************************

   // Feedback source follows the path bit; pin feedback uses the
   // resolved pin level, so a disabled cell reads the outside driver.
   // A combinational cell that drives its own pin and feeds it back
   // through an inverting polarity forms a ring with no delay in it;
   // such patterns are the user's to avoid, as on any array device
   always_comb begin
      for (int m = 0; m < pom_pkg::NUM_MC; m++) begin
         feedback[m] = outputPathSelectBit[m] ? ioIn[m] : ~flop[m]; // [R9] [R10] [R12]
      end
   end

   assign arraySig = {feedback, inPin}; // [R1]

   // Each signal reaches the array in true and complement form
   always_comb begin
      for (int k = 0; k < pom_pkg::NUM_SIG; k++) begin
         literal[2*k] = arraySig[k]; // [R5]
         literal[2*k+1] = ~arraySig[k]; // [R5]
      end
   end

   // An open connection counts as a one, so an empty term is high and
   // a term holding x and not-x is always low
   genvar t;
   generate
      for (t = 0; t < pom_pkg::PAD_TERMS; t++) begin : g_term
         if (t < pom_pkg::NUM_TERMS) begin : g_real
            assign termVal[t] = &(~termConn[t] | literal); // [R3] [R4]
         end else begin : g_pad
            assign termVal[t] = 1'b0;
         end
      end
   endgenerate

   assign asyncResetTerm = termVal[pom_pkg::AR_TERM];
   assign syncPresetTerm = termVal[pom_pkg::SP_TERM];

   // ***************************************************
   // Fixed OR array and output macrocells
   // ***************************************************

   // Only the first ptCount rows of each window feed the OR gate.
   // The window is always sixteen rows wide, so rows past the count
   // belong to the next cell, or to the zero padding after cell 9, and the mask keeps them out of this sum
   genvar m;
   generate
      for (m = 0; m < pom_pkg::NUM_MC; m++) begin : g_cell
         localparam int BASE = pom_pkg::ptBase(m);
         localparam int CNT = pom_pkg::ptCount(m);
         localparam logic [15:0] MASK = 16'(({16{1'b1}}) >> (16 - CNT));
         assign enableTerm[m] = termVal[BASE]; // [R11]
         assign orSum[m] = |(termVal[BASE+1 +: pom_pkg::MAX_PT] & MASK); // [R2]
      end
   endgenerate

   // Path 0 takes the flop, path 1 the raw sum; polarity comes last,
   // after the flop, so preset and reset never see it
   always_comb begin
      for (int k = 0; k < pom_pkg::NUM_MC; k++) begin
         cellData[k] = outputPathSelectBit[k] ? orSum[k] : flop[k]; // [R6] [R7]
         ioOut[k] = polaritySelectBit[k] ? cellData[k] : ~cellData[k]; // [R13] [R16]
      end
   end

   // Preload needs the pins free for the tester to drive;
   // enable terms are ignored meanwhile, or a stray one would fight it
   assign ioOe = preloadMode ? '0 : enableTerm; // [R11] [R18]

   // Reset term is asynchronous; it beats preset and every clocked load.
   // It is decoded from the array like any other term, so a glitch on it
   // clears the flops as well; keep that row free of racing inputs
   always_ff @(posedge clock or posedge asyncResetTerm) begin
      if (asyncResetTerm) begin
         flop <= '0; // [R15] [R19]
      end else if (reset) begin
         flop <= '0; // [R17]
      end else if (preloadMode) begin
         flop <= ioIn; // [R18]
      end else if (syncPresetTerm) begin
         flop <= '1; // [R14]
      end else begin
         flop <= orSum; // [R8]
      end
   end

   // ***************************************************
   // AXI4-Lite write channel
   // ***************************************************

   // Address and data are caught separately and joined afterwards,
   // so either may come first; a pending response blocks both
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge clock) begin
      if (reset) begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wHeld <= 1'b0;
         wData <= '0;
         wStrb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld <= 1'b1;
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   // Term rows take two words: low columns, then the top twelve.
   // Offset bit 11 must be clear, or addresses from 0xC00 up would fold
   // back onto the first rows of the array
   assign wrOffset = awAddr - pom_pkg::ARRAY_BASE;
   assign wrIdx = wrOffset[10:3];
   assign wrIsTerm = (awAddr >= pom_pkg::ARRAY_BASE) &&
                     !wrOffset[11] &&
                     (32'(wrIdx) < pom_pkg::NUM_TERMS);
   assign wrMapped = wrIsTerm || (awAddr[11:2] == pom_pkg::CTRL_ADDR[11:2]) ||
                     (awAddr[11:2] == pom_pkg::CFG_ADDR[11:2]) ||
                     (awAddr[11:2] == pom_pkg::STATUS_ADDR[11:2]);

   // Response; writes to status or holes are dropped:
   // holes answer with an error, status writes are quietly ignored
   always_ff @(posedge clock) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pom_pkg::RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? pom_pkg::RESP_OKAY : pom_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control and configuration bits; erased bits read as one.
   // Each byte strobe covers one part of a field, so software may patch
   // the polarity and path halves independently
   always_ff @(posedge clock) begin
      if (reset) begin
         preloadMode <= 1'b0;
         polaritySelectBit <= pom_pkg::CFG_ERASED; // [R7]
         outputPathSelectBit <= pom_pkg::CFG_ERASED; // [R7]
      end else if (doWrite && awAddr[11:2] == pom_pkg::CTRL_ADDR[11:2]) begin
         if (wStrb[0]) begin
            preloadMode <= wData[pom_pkg::PRELOAD_BIT];
         end
      end else if (doWrite && awAddr[11:2] == pom_pkg::CFG_ADDR[11:2]) begin
         if (wStrb[0]) begin
            polaritySelectBit[7:0] <= wData[7:0];
         end
         if (wStrb[1]) begin
            polaritySelectBit[9:8] <= wData[9:8];
         end
         if (wStrb[2]) begin
            outputPathSelectBit[7:0] <= wData[23:16];
         end
         if (wStrb[3]) begin
            outputPathSelectBit[9:8] <= wData[25:24];
         end
      end
   end

   // Connection array; reset leaves every term open.
   // Open terms evaluate high, so after reset every cell drives a one
   // and the reset term holds every flop low until software clears it
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < pom_pkg::NUM_TERMS; i++) begin
            termConn[i] <= '0;
         end
      end else if (doWrite && wrIsTerm) begin
         if (awAddr[2]) begin
            if (wStrb[0]) begin
               termConn[wrIdx][39:32] <= wData[7:0];
            end
            if (wStrb[1]) begin
               termConn[wrIdx][43:40] <= wData[11:8];
            end
         end else begin
            for (int b = 0; b < 4; b++) begin
               if (wStrb[b]) begin
                  termConn[wrIdx][8*b +: 8] <= wData[8*b +: 8];
               end
            end
         end
      end
   end

   // ***************************************************
   // AXI4-Lite read channel
   // ***************************************************
   // One read at a time; the address decode mirrors the write side
   assign s_axi_arready = !s_axi_rvalid;
   assign rdOffset = s_axi_araddr - pom_pkg::ARRAY_BASE;
   assign rdIdx = rdOffset[10:3];
   assign rdIsTerm = (s_axi_araddr >= pom_pkg::ARRAY_BASE) &&
                     !rdOffset[11] &&
                     (32'(rdIdx) < pom_pkg::NUM_TERMS);

   // Read mux; status shows flop state and pin levels
   always_comb begin
      rdWord = '0;
      rdMapped = 1'b1;
      if (rdIsTerm) begin
         if (s_axi_araddr[2]) begin
            rdWord[11:0] = termConn[rdIdx][43:32];
         end else begin
            rdWord = termConn[rdIdx][31:0];
         end
      end else if (s_axi_araddr[11:2] == pom_pkg::CTRL_ADDR[11:2]) begin
         rdWord[pom_pkg::PRELOAD_BIT] = preloadMode;
      end else if (s_axi_araddr[11:2] == pom_pkg::CFG_ADDR[11:2]) begin
         rdWord[pom_pkg::CFG_POL_LSB +: 10] = polaritySelectBit;
         rdWord[pom_pkg::CFG_PATH_LSB +: 10] = outputPathSelectBit;
      end else if (s_axi_araddr[11:2] == pom_pkg::STATUS_ADDR[11:2]) begin
         rdWord[9:0] = flop;
         rdWord[pom_pkg::STATUS_PIN_LSB +: 10] = ioIn;
      end else begin
         rdMapped = 1'b0;
      end
   end

   // Data is latched at the address handshake and held until taken.
   // Latching early means a slow rready still returns the word as it was
   // when asked, even though flops and pins move on every clock
   always_ff @(posedge clock) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= pom_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdMapped ? pom_pkg::RESP_OKAY : pom_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ### sim/pom_checker.sv
`timescale 1ns/10ps
// Bus handshakes and reset pin levels, seen from the top ports alone
module pom_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic [9:0] ioOut,
   input wire logic [9:0] ioOe,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // Open terms after reset leave every pin driven high
   a_reset_pins_high:
   assert property ($fell(reset) |-> ioOe == 10'h3FF && ioOut == 10'h3FF)
      else $error("pins not high after reset");
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_bresp_held:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_held:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_refused:
   assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_write_refused:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_error_zero:
   assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_pins_released: cover property (ioOe == 10'h000);
endmodule
bind pom_top pom_checker u_pom_checker (.clock, .reset, .ioOut, .ioOe, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .s_axi_rresp);

// ### sim/pom_board.sv
`timescale 1ns/10ps
// Board side of the cell pins; resolves each shared wire
module pom_board (
   input wire logic clock,
   input wire logic [9:0] ioOut,
   input wire logic [9:0] ioOe,
   input wire logic [9:0] drvEn,
   input wire logic [9:0] drvVal,
   output logic [9:0] ioIn
);
   logic [9:0] lastLevel;
   // A floating wire shows the inverse of its last level, never a stale copy
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         ioIn[i] = ioOe[i] ? ioOut[i] : (drvEn[i] ? drvVal[i] : ~lastLevel[i]);
      end
   end
   // Last resolved level, for the floating case
   always_ff @(posedge clock) begin
      lastLevel <= ioIn;
   end
endmodule

// ### sim/pom_top_tb.sv
`timescale 1ns/10ps
// Drives the cell array through registers and pins
module pom_top_tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [11:0] inPin = 12'h000;
   logic [9:0] ioIn, ioOut, ioOe;
   logic [9:0] drvEn = 10'h000, drvVal = 10'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, word;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int miscompares = 0;
   int checks_done = 0;
   always #25 clock = ~clock;
   pom_top u_pom_top (.clock, .reset, .inPin, .ioIn, .ioOut, .ioOe, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp);
   pom_board u_pom_board (.clock, .ioOut, .ioOe, .drvEn, .drvVal, .ioIn);
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Each channel is released at its own handshake; a spare edge avoids double drives
   task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic axiRead(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      word = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wrRow(input int r, input logic [31:0] d);
      axiWrite(12'(pom_pkg::ARRAY_BASE + 8 * r), d);
   endtask
   task automatic tReset;
      @(negedge clock);
      check("oe", 32'(ioOe), 32'h3FF);
      check("pins", 32'(ioOut), 32'h3FF);
      @(posedge clock);
      axiRead(pom_pkg::CFG_ADDR);
      check("cfg", word, 32'h03FF03FF);
      axiRead(12'h00C);
      check("rresp", 32'(resp), 32'h2);
      axiWrite(12'h00C, 32'h1);
      check("bresp", 32'(resp), 32'h2);
      axiRead(12'hC00);
      check("alias", 32'(resp), 32'h2);
      axiWrite(pom_pkg::STATUS_ADDR, 32'hFFFFFFFF);
      check("status wr", 32'(resp), 32'h0);
      axiRead(pom_pkg::STATUS_ADDR);
      check("flops low", word, 32'h03FF0000);
   endtask
   // Cell 0 combinational: input polarity per term, then output polarity
   task automatic tComb;
      wrRow(0, 32'h3);
      for (int r = 4; r <= 10; r++) wrRow(r, 32'h3);
      for (int k = 0; k < 4; k++) begin
         wrRow(3, k[0] ? 32'h8 : 32'h4);
         axiWrite(pom_pkg::CFG_ADDR, 32'h03FF03FE | 32'(!k[1]));
         for (int v = 0; v < 2; v++) begin
            inPin <= 12'(v << 1);
            @(negedge clock);
            check("comb", 32'(ioOut[0]), 32'(v ^ k[0] ^ k[1]));
            @(posedge clock);
         end
      end
   endtask
   // Registered toggle through inverted feedback, then preset and reset terms
   task automatic tReg;
      inPin <= 12'h000;
      axiWrite(pom_pkg::CFG_ADDR, 32'h03FE03FF);
      wrRow(3, 32'h01000000);
      wrRow(0, 32'h10);
      wrRow(1, 32'h4);
      @(negedge clock);
      word = 32'(ioOut[0]);
      @(negedge clock);
      check("toggle", 32'(ioOut[0]), ~word & 32'h1);
      @(posedge clock);
      inPin <= 12'h002;
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         @(negedge clock);
         check("preset", 32'(ioOut[0]), 32'h1);
      end
      @(posedge clock);
      inPin <= 12'h006;
      #1;
      check("areset", 32'(ioOut[0]), 32'h0);
      @(negedge clock);
      @(negedge clock);
      check("priority", 32'(ioOut[0]), 32'h0);
      @(posedge clock);
      axiWrite(pom_pkg::CFG_ADDR, 32'h03FE03FE);
      check("inverted", 32'(ioOut[0]), 32'h1);
      inPin <= 12'h000;
   endtask
   // Enable term, then cell 0 as an input read back through cell 1
   task automatic tOe;
      axiWrite(pom_pkg::CFG_ADDR, 32'h03FF03FF);
      wrRow(2, 32'h40);
      for (int v = 0; v < 2; v++) begin
         inPin <= 12'(v << 3);
         @(negedge clock);
         check("oe", 32'(ioOe[0]), 32'(v));
         @(posedge clock);
      end
      wrRow(2, 32'h3);
      for (int r = 13; r <= 21; r++) wrRow(r, 32'h3);
      wrRow(12, 32'h01000000);
      drvEn <= 10'h001;
      for (int v = 0; v < 2; v++) begin
         drvVal <= 10'(v);
         @(negedge clock);
         check("pin in", 32'(ioOut[1]), 32'(v));
         @(posedge clock);
      end
      drvEn <= 10'h000;
   endtask
   task automatic tPreload;
      axiWrite(pom_pkg::CTRL_ADDR, 32'h1);
      drvEn <= 10'h3FF;
      drvVal <= 10'h2A5;
      @(negedge clock);
      check("preload oe", 32'(ioOe), 32'h0);
      repeat (2) @(posedge clock);
      axiRead(pom_pkg::STATUS_ADDR);
      check("preload", word, 32'h02A502A5);
      axiWrite(pom_pkg::CTRL_ADDR, 32'h0);
      drvEn <= 10'h000;
   endtask
   // A hang costs one mismatch and still reaches the verdict
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      complete_run;
   end
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      tReset;
      tComb;
      tReg;
      tOe;
      tPreload;
      complete_run;
   end
endmodule
